// File: hdl/osr_defs.svh
/*
 Constants for the OTP and suspend/resume sequencer: opcodes, OTP geometry,
 flag status bit positions and timing counts.
 Assumes a 100 MHz system clock and inclusion by its bare name.
*/
// Overview of operation
// - resume is one opcode framed by chip select low, executed when chip select rises
// - accepted resume sets write-in-progress and clears the controller-ready flag bit
// - resume is ignored when nothing is suspended
// - a resumed operation finishing sets the controller-ready flag bit again
// - program suspended: reads of the suspended page are flagged indeterminate
// - erase suspended: program and read allowed outside the suspended sector
// - subsector erase suspended: whole containing sector reads indeterminate
// - program to an erase-suspended sector is rejected, flag bit 4 set, latch kept
// - erase resume does not re-evaluate volatile lock bits
// - OTP read samples address on rising edges, drives data on falling edges
// - OTP read address increments per byte and sticks at location 0x40
// - chip select high ends an OTP read at any time
// - OTP program ignored with no flags unless write-enable latch is set
// - frame not ending on a byte boundary is skipped, no flags, latch kept
// - OTP program takes at most 65 data bytes, later bytes discarded
// - OTP program is self-timed from chip select rise, write-in-progress held
// - OTP program end clears write-enable latch and write-in-progress
// - OTP program timeout clears the latch and sets the program-fail flag
// - completion is seen as flag status bit 7 reading 1
// - lock byte bit 0 defaults to 1, once programmed to 0 stays 0
// - locked OTP ignores program, keeps latch, sets flag bits 1 and 4
// - program suspend sets flag bit 2, erase suspend sets flag bit 6
// - one nesting level: erase then program suspended, resumed in reverse order
`ifndef OSR_DEFS_SVH
`define OSR_DEFS_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define OSR_OP_RESUME        8'h7A
`define OSR_OP_OTP_READ      8'h4B
`define OSR_OP_OTP_PROG      8'h42

// ----------------------------------------
// OTP geometry
// ----------------------------------------
`define OSR_OTP_LAST         7'h40
`define OSR_OTP_MAX_BYTES    7'h41
`define OSR_OTP_DEPTH        65
`define OSR_OTP_ERASED       8'hFF
`define OSR_LOCK_BIT         0

// ----------------------------------------
// flag status bit positions and address split
// ----------------------------------------
`define OSR_FSR_READY        7
`define OSR_FSR_ERS_SUSP     6
`define OSR_FSR_PROG_FAIL    4
`define OSR_FSR_PRG_SUSP     2
`define OSR_FSR_PROT         1
`define OSR_PAGE_LSB         8
`define OSR_SECTOR_LSB       16

// ----------------------------------------
// timing
// ----------------------------------------
`define OSR_CLK_PERIOD_NS    10
`define OSR_DUMMY_CYCLES     8
`define OSR_OTP_PROG_TIME_US 2000
`define OSR_OTP_PROG_CYCLES  ((`OSR_OTP_PROG_TIME_US * 1000) / `OSR_CLK_PERIOD_NS)

`endif

// File: hdl/osr_pkg.sv
/*
 Types for the OTP and suspend/resume sequencer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package osr_pkg;

   // serial frame decoder states
   typedef enum logic [5:0] {
      FR_OPCODE = 6'b000001,
      FR_ADDR   = 6'b000010,
      FR_DUMMY  = 6'b000100,
      FR_RDATA  = 6'b001000,
      FR_WDATA  = 6'b010000,
      FR_SKIP   = 6'b100000
   } osr_frame_t;

   // OTP program engine states
   typedef enum logic [3:0] {
      EN_IDLE  = 4'b0001,
      EN_FETCH = 4'b0010,
      EN_WRITE = 4'b0100,
      EN_WAIT  = 4'b1000
   } osr_eng_t;

   // array operation currently running
   typedef enum logic [2:0] {
      RUN_NONE  = 3'b001,
      RUN_PROG  = 3'b010,
      RUN_ERASE = 3'b100
   } osr_run_t;

endpackage : osr_pkg

// File: hdl/osr_byte_mem.sv
/*
 Small byte memory with one write port and a registered read port.
 Assumes a single clock; reset fills every location with the erased value.
*/
`timescale 1ns/1ps
`default_nettype none
`include "osr_defs.svh"

module osr_byte_mem #(
   parameter int unsigned DEPTH = `OSR_OTP_DEPTH,
   parameter int unsigned AW    = 7
) (
   input  wire logic          clock,
   input  wire logic          rst_n,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [7:0]    wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [7:0]    rdata_q
);

   logic [7:0] mem_q [DEPTH];

   // --------------------------------
   // storage
   // --------------------------------
   // erased state is all ones; a write stores wdata as given, so it can set bits as well as clear them
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= `OSR_OTP_ERASED;
         end
      end else if (we) begin
         mem_q[waddr] <= wdata;
      end
   end

   // registered read, one cycle behind the address
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= mem_q[raddr];
      end
   end

endmodule : osr_byte_mem
`default_nettype wire

// File: hdl/osr_seq.sv
/*
 Serial flash sequencer for program/erase resume and the OTP area:
 frame decoder on the serial pins, OTP read and program, suspend bookkeeping
 and the status/flag status bits it owns.
 Assumes the serial pins are asynchronous and the serial clock is far slower
 than the system clock; array start/done/suspend events come from logic on
 the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "osr_defs.svh"

module osr_seq #(
   parameter int unsigned OTP_PROG_CYCLES = `OSR_OTP_PROG_CYCLES,
   parameter int unsigned DUMMY_CYCLES    = `OSR_DUMMY_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        cs_n_pin,
   input  wire logic        sclk_pin,
   input  wire logic        serial_input_line,
   output logic             serial_output_line,
   output logic             serial_output_oe_n,
   input  wire logic        addr_4byte,
   input  wire logic        wel_set,
   input  wire logic        fsr_clear,
   input  wire logic        array_prog_start,
   input  wire logic        array_erase_start,
   input  wire logic        array_done,
   input  wire logic        suspend_req,
   input  wire logic [31:0] array_addr,
   input  wire logic [31:0] access_addr,
   input  wire logic        prog_cmd_req,
   input  wire logic        otp_prog_timeout,
   output logic             wel,
   output logic             wip,
   output logic [7:0]       flag_status,
   output logic             read_indeterminate,
   output logic             program_allowed,
   output logic             resume_program,
   output logic             resume_erase,
   output logic             otp_locked
);

   // clamp a received address into the OTP window
   function automatic logic [6:0] otp_loc(input logic [31:0] a);
      otp_loc = (a > 32'(`OSR_OTP_LAST)) ? `OSR_OTP_LAST : a[6:0];
   endfunction : otp_loc

   // --------------------------------
   // pin synchronisers and edge detect
   // --------------------------------
   logic [1:0] cs_sync_q;
   logic [1:0] ck_sync_q;
   logic [1:0] di_sync_q;
   logic       ck_prev_q;
   logic       cs_prev_q;
   logic       cs_high;
   logic       sck_rise;
   logic       sck_fall;
   logic       cs_rise;
   logic       din;

   // all three pins share the same delay so data stays aligned to the clock edge
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cs_sync_q <= 2'h3;
         ck_sync_q <= 2'h0;
         di_sync_q <= 2'h0;
         ck_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end else begin
         cs_sync_q <= {cs_sync_q[0], cs_n_pin};
         ck_sync_q <= {ck_sync_q[0], sclk_pin};
         di_sync_q <= {di_sync_q[0], serial_input_line};
         ck_prev_q <= ck_sync_q[1];
         cs_prev_q <= cs_sync_q[1];
      end
   end

   assign cs_high  = cs_sync_q[1];
   assign sck_rise = ~cs_high & ck_sync_q[1] & ~ck_prev_q;
   assign sck_fall = ~cs_high & ~ck_sync_q[1] & ck_prev_q;
   assign cs_rise  = cs_high & ~cs_prev_q;
   assign din      = di_sync_q[1];

   // --------------------------------
   // frame decoder
   // --------------------------------
   osr_pkg::osr_frame_t frame_q;
   osr_pkg::osr_eng_t   eng_q;
   osr_pkg::osr_run_t   run_q;
   logic [7:0]  shift_q;
   logic [2:0]  bit_cnt_q;
   logic [7:0]  opcode_q;
   logic [31:0] addr_q;
   logic [6:0]  cnt_q;
   logic [6:0]  base_q;
   logic [6:0]  rd_addr_q;
   logic [2:0]  out_bit_q;
   logic        got_byte_q;
   logic [7:0]  byte_in;
   logic        byte_done;
   logic [31:0] addr_full;
   logic        stage_we;
   logic [7:0]  otp_rdata;
   logic [7:0]  stage_rdata;

   assign byte_in   = {shift_q[6:0], din};
   assign byte_done = sck_rise && (bit_cnt_q == 3'h7);
   assign addr_full = {addr_q[23:0], byte_in};
   // bytes past the 65th or past the lock byte are dropped
   assign stage_we  = (frame_q == osr_pkg::FR_WDATA) && byte_done &&
                      (cnt_q < `OSR_OTP_MAX_BYTES) &&
                      (7'(base_q + cnt_q) <= `OSR_OTP_LAST);

   // chip select high parks the decoder; the frame's result is judged on that same edge
   always_ff @(posedge clock) begin
      if (!rst_n || cs_high) begin
         frame_q            <= osr_pkg::FR_OPCODE;
         shift_q            <= 8'h00;
         bit_cnt_q          <= 3'h0;
         opcode_q           <= 8'h00;
         addr_q             <= 32'h0000_0000;
         cnt_q              <= 7'h00;
         base_q             <= 7'h00;
         rd_addr_q          <= 7'h00;
         out_bit_q          <= 3'h0;
         got_byte_q         <= 1'b0;
         serial_output_line <= 1'b0;
         serial_output_oe_n <= 1'b1;
      end else begin
         if (sck_rise) begin
            shift_q   <= byte_in;
            bit_cnt_q <= bit_cnt_q + 3'h1;
         end
         case (frame_q)
            osr_pkg::FR_OPCODE: begin
               if (byte_done) begin
                  opcode_q <= byte_in;
                  cnt_q    <= 7'h00;
                  if (byte_in == `OSR_OP_OTP_READ || byte_in == `OSR_OP_OTP_PROG) begin
                     frame_q <= osr_pkg::FR_ADDR;
                  end else begin
                     frame_q <= osr_pkg::FR_SKIP;
                  end
               end
            end
            osr_pkg::FR_ADDR: begin
               if (byte_done) begin
                  addr_q <= addr_full;
                  if (cnt_q == (addr_4byte ? 7'h03 : 7'h02)) begin
                     cnt_q     <= 7'h00;
                     rd_addr_q <= otp_loc(addr_full);
                     base_q    <= otp_loc(addr_full);
                     frame_q   <= (opcode_q == `OSR_OP_OTP_READ) ? osr_pkg::FR_DUMMY
                                                                 : osr_pkg::FR_WDATA;
                  end else begin
                     cnt_q <= cnt_q + 7'h01;
                  end
               end
            end
            osr_pkg::FR_DUMMY: begin
               if (sck_rise) begin
                  cnt_q <= cnt_q + 7'h01;
                  if (cnt_q == 7'(DUMMY_CYCLES - 1)) begin
                     frame_q <= osr_pkg::FR_RDATA;
                  end
               end
            end
            osr_pkg::FR_RDATA: begin
               // memory read data settles long before the next falling edge
               if (sck_fall) begin
                  serial_output_line <= otp_rdata[3'h7 - out_bit_q];
                  serial_output_oe_n <= 1'b0;
                  out_bit_q          <= out_bit_q + 3'h1;
                  if (out_bit_q == 3'h7 && rd_addr_q != `OSR_OTP_LAST) begin
                     rd_addr_q <= rd_addr_q + 7'h01;
                  end
               end
            end
            osr_pkg::FR_WDATA: begin
               if (byte_done) begin
                  got_byte_q <= 1'b1;
                  if (stage_we) begin
                     cnt_q <= cnt_q + 7'h01;
                  end
               end
            end
            osr_pkg::FR_SKIP: begin
               cnt_q <= cnt_q;  // opcode not handled here, wait for chip select
            end
            default: begin
               frame_q <= osr_pkg::FR_OPCODE;
            end
         endcase
      end
   end

   // --------------------------------
   // frame results on chip select rise
   // --------------------------------
   logic wel_q;
   logic wip_q;
   logic ready_q;
   logic prg_susp_q;
   logic ers_susp_q;
   logic prog_fail_q;
   logic prot_q;
   logic lock_q;
   logic frame_whole;
   logic resume_cmd;
   logic otp_cmd;
   logic otp_go;
   logic otp_lock_rej;
   logic otp_done;
   logic otp_abort;

   assign frame_whole  = cs_rise && (bit_cnt_q == 3'h0);
   assign resume_cmd   = frame_whole && (frame_q == osr_pkg::FR_SKIP) &&
                         (opcode_q == `OSR_OP_RESUME);
   // a command arriving while another write is in progress is dropped quietly
   assign otp_cmd      = frame_whole && (frame_q == osr_pkg::FR_WDATA) && got_byte_q &&
                         wel_q && !wip_q && (eng_q == osr_pkg::EN_IDLE);
   assign otp_go       = otp_cmd && lock_q;
   assign otp_lock_rej = otp_cmd && !lock_q;

   // --------------------------------
   // OTP program engine
   // --------------------------------
   logic [6:0]  idx_q;
   logic [6:0]  count_q;
   logic [6:0]  prog_base_q;
   logic [31:0] timer_q;
   logic [6:0]  tgt;
   logic [7:0]  prog_byte;

   assign tgt       = 7'(prog_base_q + idx_q);
   assign prog_byte = otp_rdata & stage_rdata;  // cells only go from 1 to 0
   assign otp_done  = (eng_q == osr_pkg::EN_WAIT) && (timer_q == 32'h0000_0000);
   assign otp_abort = otp_prog_timeout && (eng_q != osr_pkg::EN_IDLE);

   // two cycles per byte; the timer covers the whole duration from the start
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         eng_q       <= osr_pkg::EN_IDLE;
         idx_q       <= 7'h00;
         count_q     <= 7'h00;
         prog_base_q <= 7'h00;
         timer_q     <= 32'h0000_0000;
         lock_q      <= 1'b1;
      end else begin
         if (timer_q != 32'h0000_0000) begin
            timer_q <= timer_q - 32'h0000_0001;
         end
         case (eng_q)
            osr_pkg::EN_IDLE: begin
               if (otp_go) begin
                  eng_q       <= osr_pkg::EN_FETCH;
                  idx_q       <= 7'h00;
                  count_q     <= cnt_q;
                  prog_base_q <= base_q;
                  timer_q     <= OTP_PROG_CYCLES;
               end
            end
            osr_pkg::EN_FETCH: begin
               eng_q <= osr_pkg::EN_WRITE;
            end
            osr_pkg::EN_WRITE: begin
               idx_q <= idx_q + 7'h01;
               if (tgt == `OSR_OTP_LAST) begin
                  lock_q <= lock_q & prog_byte[`OSR_LOCK_BIT];
               end
               eng_q <= (7'(idx_q + 7'h01) == count_q) ? osr_pkg::EN_WAIT : osr_pkg::EN_FETCH;
            end
            osr_pkg::EN_WAIT: begin
               if (timer_q == 32'h0000_0000) begin
                  eng_q <= osr_pkg::EN_IDLE;
               end
            end
            default: begin
               eng_q <= osr_pkg::EN_IDLE;
            end
         endcase
         if (otp_abort) begin
            eng_q <= osr_pkg::EN_IDLE;
         end
      end
   end

   // OTP array and the staging buffer that holds bytes until the frame is whole
   osr_byte_mem #(.DEPTH(`OSR_OTP_DEPTH), .AW(7)) u_otp (
      .clock   (clock),
      .rst_n   (rst_n),
      .we      (eng_q == osr_pkg::EN_WRITE),
      .waddr   (tgt),
      .wdata   (prog_byte),
      .raddr   ((eng_q != osr_pkg::EN_IDLE) ? tgt : rd_addr_q),
      .rdata_q (otp_rdata)
   );

   osr_byte_mem #(.DEPTH(`OSR_OTP_DEPTH), .AW(7)) u_stage (
      .clock   (clock),
      .rst_n   (rst_n),
      .we      (stage_we),
      .waddr   (cnt_q),
      .wdata   (byte_in),
      .raddr   (idx_q),
      .rdata_q (stage_rdata)
   );

   // --------------------------------
   // suspend bookkeeping and status bits
   // --------------------------------
   logic [31:0] run_addr_q;
   logic [31:0] prg_addr_q;
   logic [31:0] ers_addr_q;
   logic        ers_hit;
   logic        prg_hit;

   assign ers_hit = ers_susp_q &&
                    (access_addr[31:`OSR_SECTOR_LSB] == ers_addr_q[31:`OSR_SECTOR_LSB]);
   assign prg_hit = prg_susp_q &&
                    (access_addr[31:`OSR_PAGE_LSB] == prg_addr_q[31:`OSR_PAGE_LSB]);

   // later assignments win, so every set below overrides the clear above it
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wel_q          <= 1'b0;
         wip_q          <= 1'b0;
         ready_q        <= 1'b1;
         prg_susp_q     <= 1'b0;
         ers_susp_q     <= 1'b0;
         prog_fail_q    <= 1'b0;
         prot_q         <= 1'b0;
         run_q          <= osr_pkg::RUN_NONE;
         run_addr_q     <= 32'h0000_0000;
         prg_addr_q     <= 32'h0000_0000;
         ers_addr_q     <= 32'h0000_0000;
         resume_program <= 1'b0;
         resume_erase   <= 1'b0;
      end else begin
         resume_program <= 1'b0;
         resume_erase   <= 1'b0;
         if (fsr_clear) begin
            prog_fail_q <= 1'b0;
            prot_q      <= 1'b0;
         end
         if (wel_set) begin
            wel_q <= 1'b1;
         end
         if (array_prog_start || array_erase_start) begin
            run_q      <= array_prog_start ? osr_pkg::RUN_PROG : osr_pkg::RUN_ERASE;
            run_addr_q <= array_addr;
            wip_q      <= 1'b1;
            ready_q    <= 1'b0;
         end
         if (array_done && run_q != osr_pkg::RUN_NONE) begin
            run_q   <= osr_pkg::RUN_NONE;
            wip_q   <= 1'b0;
            wel_q   <= 1'b0;
            ready_q <= 1'b1;
         end
         if (suspend_req && run_q == osr_pkg::RUN_PROG && !prg_susp_q) begin
            prg_susp_q <= 1'b1;
            prg_addr_q <= run_addr_q;
            run_q      <= osr_pkg::RUN_NONE;
            wip_q      <= 1'b0;
            ready_q    <= 1'b1;
         end
         if (suspend_req && run_q == osr_pkg::RUN_ERASE && !ers_susp_q) begin
            ers_susp_q <= 1'b1;
            ers_addr_q <= run_addr_q;
            run_q      <= osr_pkg::RUN_NONE;
            wip_q      <= 1'b0;
            ready_q    <= 1'b1;
         end
         // the nested program comes back first, the erase beneath it second
         if (resume_cmd && run_q == osr_pkg::RUN_NONE && (prg_susp_q || ers_susp_q)) begin
            wip_q   <= 1'b1;
            ready_q <= 1'b0;
            if (prg_susp_q) begin
               prg_susp_q     <= 1'b0;
               run_q          <= osr_pkg::RUN_PROG;
               run_addr_q     <= prg_addr_q;
               resume_program <= 1'b1;
            end else begin
               ers_susp_q     <= 1'b0;
               run_q          <= osr_pkg::RUN_ERASE;
               run_addr_q     <= ers_addr_q;
               resume_erase   <= 1'b1;
            end
         end
         if (prog_cmd_req && ers_hit) begin
            prog_fail_q <= 1'b1;
         end
         if (otp_go) begin
            wip_q   <= 1'b1;
            ready_q <= 1'b0;
         end
         if (otp_lock_rej) begin
            prot_q      <= 1'b1;
            prog_fail_q <= 1'b1;
         end
         if (otp_done || otp_abort) begin
            wip_q   <= 1'b0;
            wel_q   <= 1'b0;
            ready_q <= 1'b1;
         end
         if (otp_abort) begin
            prog_fail_q <= 1'b1;
         end
      end
   end

   // --------------------------------
   // outputs
   // --------------------------------
   assign wel                = wel_q;
   assign wip                = wip_q;
   assign otp_locked         = ~lock_q;
   assign read_indeterminate = prg_hit | ers_hit;
   assign program_allowed    = ~ers_hit;

   always_comb begin
      flag_status                     = 8'h00;
      flag_status[`OSR_FSR_READY]     = ready_q;
      flag_status[`OSR_FSR_ERS_SUSP]  = ers_susp_q;
      flag_status[`OSR_FSR_PROG_FAIL] = prog_fail_q;
      flag_status[`OSR_FSR_PRG_SUSP]  = prg_susp_q;
      flag_status[`OSR_FSR_PROT]      = prot_q;
   end

endmodule : osr_seq
`default_nettype wire

// File: tb/osr_seq_checker.sv
/* Port assertions for osr_seq.
   Assumes it is bound to every osr_seq instance. */
`timescale 1ns/1ps
`default_nettype none
module osr_seq_checker (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic       cs_n_pin,
   input wire logic       prog_cmd_req,
   input wire logic       otp_prog_timeout,
   input wire logic       fsr_clear,
   input wire logic       serial_output_oe_n,
   input wire logic       wel,
   input wire logic       wip,
   input wire logic [7:0] flag_status,
   input wire logic       read_indeterminate,
   input wire logic       program_allowed,
   input wire logic       resume_program,
   input wire logic       resume_erase,
   input wire logic       otp_locked
);
   // reset is synchronous, so nothing is judged while it is held
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   res_busy_a: assert property ((resume_program || resume_erase) |-> ##[0:2] (wip && !flag_status[7]))
      else $error("resume left device idle");
   res_order_a: assert property (resume_erase |-> !$past(flag_status[2]))
      else $error("erase resumed before program");
   oe_idle_a: assert property (cs_n_pin [*5] |-> serial_output_oe_n)
      else $error("output driven while deselected");
   rej_prog_a: assert property (prog_cmd_req && !program_allowed |=> flag_status[4] && (wel == $past(wel)))
      else $error("program in suspended sector not flagged");
   indet_rd_a: assert property (!program_allowed |-> read_indeterminate && flag_status[6])
      else $error("suspended sector read not indeterminate");
   tmo_fail_a: assert property (otp_prog_timeout && wip |=> flag_status[4] && !wel)
      else $error("timeout did not fail program");
   err_keep_a: assert property (flag_status[4] && !fsr_clear |=> flag_status[4])
      else $error("error flag dropped");
   lock_hold_a: assert property (otp_locked |=> otp_locked)
      else $error("lock released");
endmodule : osr_seq_checker
bind osr_seq osr_seq_checker u_chk (.clock, .rst_n, .cs_n_pin, .prog_cmd_req, .otp_prog_timeout, .fsr_clear,
   .serial_output_oe_n, .wel, .wip, .flag_status, .read_indeterminate, .program_allowed,
   .resume_program, .resume_erase, .otp_locked);
`default_nettype wire

// File: tb/osr_host.sv
/* Serial host model, mode 0, 125 ns link clock.
   Assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
`default_nettype none
module osr_host (
   output logic     cs_n,
   output logic     sclk,
   output logic     mosi,
   input wire logic miso
);
   initial {cs_n, sclk, mosi} = 3'h4;
   // msb first; data set while clock low, sampled by both sides at the rise
   task automatic shift(input logic [7:0] b, input int n, output logic [7:0] r);
      r = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         mosi = b[i];
         #62 sclk = 1'b1;
         r[i] = miso;
         #63 sclk = 1'b0;
      end
   endtask : shift
   task automatic open_f();
      #60 cs_n = 1'b0;
   endtask : open_f
   // released data line flips so a stale bit is not taken as driven
   task automatic close_f();
      #60 cs_n = 1'b1;
      mosi = ~mosi;
      #400;
   endtask : close_f
endmodule : osr_host
`default_nettype wire

// File: tb/testbench.sv
/* Self-checking bench for osr_seq: serial host model, side-port pulses.
   Assumes the design and checker files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       clock, rst_n, cs_n, sclk, mosi, miso, oe_n, wel, wip, rd_ind, p_ok, r_prg, r_ers, lock, a4 = 1'b0;
   logic [7:0] ev, fsr, rx[$];
   logic [31:0] a_addr, x_addr;
   int         bad_count, compares, n_rp, n_re;
   osr_host u_host (.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));
   osr_seq #(.OTP_PROG_CYCLES(200)) u_dut (.clock(clock), .rst_n(rst_n), .cs_n_pin(cs_n), .sclk_pin(sclk),
      .serial_input_line(mosi), .serial_output_line(miso), .serial_output_oe_n(oe_n), .addr_4byte(a4),
      .wel_set(ev[0]), .fsr_clear(ev[1]), .array_prog_start(ev[2]), .array_erase_start(ev[3]),
      .array_done(ev[4]), .suspend_req(ev[5]), .array_addr(a_addr), .access_addr(x_addr),
      .prog_cmd_req(ev[6]), .otp_prog_timeout(ev[7]), .wel(wel), .wip(wip), .flag_status(fsr),
      .read_indeterminate(rd_ind), .program_allowed(p_ok), .resume_program(r_prg), .resume_erase(r_ers),
      .otp_locked(lock));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // resume pulses last one cycle, so they are counted
   always @(posedge clock) begin
      if (r_prg === 1'b1) n_rp++;
      if (r_ers === 1'b1) n_re++;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic pulse(input int i);
      @(posedge clock) #1 ev[i] = 1'b1;
      @(posedge clock) #1 ev[i] = 1'b0;
   endtask : pulse
   // send n whole bytes (top first), then tail loose bits, then read nrd bytes
   task automatic frame(input logic [63:0] tx, input int n, input int tail, input int nrd);
      logic [7:0] r;
      rx = {};
      u_host.open_f();
      for (int i = n - 1; i >= 0; i--) u_host.shift(tx[8*i+:8], 8, r);
      if (tail > 0) u_host.shift(8'hFF, tail, r);
      repeat (nrd) begin
         u_host.shift(8'h00, 8, r);
         rx.push_back(r);
      end
      u_host.close_f();
   endtask : frame
   task automatic wait_idle();
      for (int i = 0; i < 400 && wip !== 1'b0; i++) @(posedge clock);
      if (wip !== 1'b0) bad_count++;
   endtask : wait_idle
   task automatic t_otp_prog();
      frame(64'h420000005A, 5, 0, 0);
      chk("wip", 8'h00, wip);
      chk("fsr", 8'h80, fsr);
      pulse(0);
      frame(64'h4200003EA53C, 6, 0, 0);
      chk("wip", 8'h01, wip);
      chk("fsr", 8'h00, fsr);
      wait_idle();
      chk("wel", 8'h00, wel);
      chk("fsr", 8'h80, fsr);
      frame(64'h4B00003E00, 5, 0, 3);
      chk("rd0", 8'hA5, rx[0]);
      chk("rd1", 8'h3C, rx[1]);
      chk("rd2", 8'hFF, rx[2]);
   endtask : t_otp_prog
   task automatic t_otp_cut();
      pulse(0);
      frame(64'h4200001000, 5, 4, 0);
      chk("wip", 8'h00, wip);
      chk("wel", 8'h01, wel);
      chk("fsr", 8'h80, fsr);
      frame(64'h4200001077, 5, 0, 0);
      pulse(7);
      chk("wel", 8'h00, wel);
      chk("fail", 8'h01, fsr[4]);
      wait_idle();
      pulse(1);
      chk("fail", 8'h00, fsr[4]);
   endtask : t_otp_cut
   task automatic t_resume();
      frame(64'h7A, 1, 0, 0);
      chk("res", 8'h00, 8'(n_rp + n_re));
      a_addr = 32'h0002_0000;
      pulse(3);
      pulse(5);
      chk("fsr", 8'hC0, fsr);
      x_addr = 32'h0002_F123;
      pulse(0);
      pulse(6);
      chk("ok", 8'h00, p_ok);
      chk("ind", 8'h01, rd_ind);
      chk("fsr", 8'hD0, fsr);
      chk("wel", 8'h01, wel);
      x_addr = 32'h0003_0000;
      #1 chk("ok", 8'h01, p_ok);
      a_addr = 32'h0003_0100;
      pulse(2);
      pulse(5);
      x_addr = 32'h0003_01FF;
      #1 chk("ind", 8'h01, rd_ind);
      chk("fsr", 8'hD4, fsr);
      frame(64'h7A, 1, 0, 0);
      chk("rp", 8'h01, 8'(n_rp));
      chk("fsr", 8'h50, fsr);
      chk("wip", 8'h01, wip);
      pulse(4);
      chk("fsr", 8'hD0, fsr);
      frame(64'h7A, 1, 0, 0);
      chk("re", 8'h01, 8'(n_re));
      chk("fsr", 8'h10, fsr);
      pulse(4);
      pulse(1);
      chk("fsr", 8'h80, fsr);
   endtask : t_resume
   task automatic t_lock();
      pulse(0);
      frame(64'h4200003F3CFE, 6, 0, 0);
      wait_idle();
      chk("lock", 8'h01, lock);
      @(posedge clock) #1 a4 = 1'b1;
      frame(64'h4B0000003F00, 6, 0, 4);
      foreach (rx[i]) chk("rd", (i == 0) ? 8'h3C : 8'hFE, rx[i]);
      pulse(0);
      frame(64'h420000000011, 6, 0, 0);
      chk("fsr", 8'h92, fsr);
      chk("wel", 8'h01, wel);
   endtask : t_lock
   task automatic stop_test();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   initial begin
      #200000 bad_count++;
      stop_test();
   end
   initial begin
      rst_n = 1'b0;
      ev = 8'h00;
      a_addr = 32'h0;
      x_addr = 32'h0;
      repeat (6) @(posedge clock);
      #1 rst_n = 1'b1;
      repeat (5) @(posedge clock);
      t_otp_prog();
      t_otp_cut();
      t_resume();
      t_lock();
      stop_test();
   end
endmodule : testbench
`default_nettype wire
